/* File: common/ulfc_pkg.sv */
// Constants and carrier types for the line and queue control block
// Behaviour
// RQ1 - Identity field reports highest-priority pending source
// RQ2 - Receive flush empties receive queue, self-clearing
// RQ3 - Queue enable bit 0, reset one
// RQ4 - Changing queue enable resets both queues
// RQ5 - Divisor access bit maps divisor latch bytes
// RQ6 - Divisor access bit writes ignored while busy
// RQ7 - Software clears divisor access after baud setup
// RQ8 - Break control drives serial output low
// RQ9 - Outside loopback, output low while break set
// RQ10 - Infrared break outside loopback pulses continuously
// RQ11 - Loopback break goes internal, infrared forced low
// RQ12 - Priority: line status, receive, transmit, busy
package ulfc_pkg;

	// Register byte addresses
	localparam logic [31:0] ULFC_DATA_ADR   = 32'h50001000;
	localparam logic [31:0] ULFC_DIVHI_ADR  = 32'h50001004;
	localparam logic [31:0] ULFC_QCTL_ADR   = 32'h50001008;
	localparam logic [31:0] ULFC_LCR_ADR    = 32'h5000100c;
	localparam logic [31:0] ULFC_MCR_ADR    = 32'h50001010;
	localparam logic [31:0] ULFC_STAT_ADR   = 32'h50001014;
	localparam logic [31:0] ULFC_ISTS_ADR   = 32'h50001018;
	localparam logic [31:0] ULFC_IMASK_ADR  = 32'h5000101c;

	// Line control fields
	localparam int          ULFC_LCR_DLAB   = 7;
	localparam int          ULFC_LCR_BC     = 6;
	localparam logic [15:0] ULFC_LCR_RST    = 16'h0000;
	localparam logic [15:0] ULFC_LCR_WMASK  = 16'h00df;
	localparam logic [15:0] ULFC_LCR_BUSYMSK = 16'h0040;

	// Modem control fields
	localparam int          ULFC_MCR_LOOP   = 4;
	localparam int          ULFC_MCR_IR     = 6;
	localparam logic [7:0]  ULFC_MCR_RST    = 8'h00;

	// Queue control write fields and identity read fields
	localparam int          ULFC_QC_EN      = 0;
	localparam int          ULFC_QC_RXFL    = 1;
	localparam int          ULFC_QC_TXFL    = 2;
	localparam logic        ULFC_QEN_RST    = 1'h1;
	localparam int          ULFC_ID_QEN_LO  = 6;
	localparam int          ULFC_ID_QEN_HI  = 7;

	// Interrupt identity codes
	localparam logic [3:0]  ULFC_IID_NONE   = 4'h1;
	localparam logic [3:0]  ULFC_IID_THRE   = 4'h2;
	localparam logic [3:0]  ULFC_IID_RDA    = 4'h4;
	localparam logic [3:0]  ULFC_IID_LSR    = 4'h6;
	localparam logic [3:0]  ULFC_IID_BUSY   = 4'h7;
	localparam logic [3:0]  ULFC_IID_TMO    = 4'hc;

	// Event bit positions in interrupt status and mask
	localparam int          ULFC_EV_LSR     = 0;
	localparam int          ULFC_EV_RDA     = 1;
	localparam int          ULFC_EV_TMO     = 2;
	localparam int          ULFC_EV_THRE    = 3;
	localparam int          ULFC_EV_BUSY    = 4;
	localparam int          ULFC_EV_W       = 5;
	localparam logic [4:0]  ULFC_IMASK_RST  = 5'h00;

	// Status register fields
	localparam int          ULFC_ST_BUSY    = 0;
	localparam int          ULFC_ST_TXCNT   = 8;
	localparam int          ULFC_ST_RXCNT   = 16;

	// Queue depth and infrared break pulse timing
	localparam int          ULFC_QUEUE_DEPTH = 16;
	localparam int          ULFC_CLK_NS     = 8;
	localparam int          ULFC_IR_PER_NS  = 1000;
	localparam int          ULFC_IR_LOW_NS  = 200;
	localparam int          ULFC_IR_PER_CYC = ULFC_IR_PER_NS / ULFC_CLK_NS;
	localparam int          ULFC_IR_LOW_CYC = (ULFC_IR_LOW_NS + ULFC_CLK_NS - 1) / ULFC_CLK_NS;

	// Signals from the framing engine, same clock
	typedef struct packed {
		logic       busy;
		logic       ser_tx;
		logic       ir_pulse_n;
		logic       line_status;
		logic       char_timeout;
		logic       tx_pop;
		logic       rx_push;
		logic [7:0] rx_data;
	} ulfc_frm_in_t;

	// Signals to the framing engine
	typedef struct packed {
		logic [7:0]  tx_data;
		logic        tx_push;
		logic        loop_break;
		logic        loopback;
		logic        queue_enable;
		logic [15:0] divisor;
		logic [15:0] line_control;
	} ulfc_frm_out_t;

endpackage : ulfc_pkg

/* File: src/ulfc_queue_ctl.sv */
// Control portion of one character queue: occupancy count, empty and full
`timescale 1ns/10ps
module ulfc_queue_ctl #(
	parameter int DEPTH = 16,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// Queue events
	input  wire logic          push_i,
	input  wire logic          pop_i,
	input  wire logic          clear_i,
	input  wire logic          single_i,
	// Queue state
	output logic [CW-1:0]      count_o,
	output logic               empty_o,
	output logic               full_o
);
	typedef struct packed {
		logic [CW-1:0] count;
		logic          empty;
		logic          full;
	} ulfc_qstate_t;

	ulfc_qstate_t s_q;
	ulfc_qstate_t s_d;
	logic         inc;
	logic         dec;

	// A push into a full queue or a pop from an empty one is dropped
	assign inc = push_i & ~s_q.full;
	assign dec = pop_i & ~s_q.empty;

	// Next count; clear wins because it stands for a controller reset
	always_comb begin
		s_d = s_q;
		if (clear_i) begin
			s_d.count = '0;
		end else if (inc && !dec) begin
			s_d.count = s_q.count + CW'(1);
		end else if (dec && !inc) begin
			s_d.count = s_q.count - CW'(1);
		end
		s_d.empty = (s_d.count == '0);
		// With queues disabled only one character is held
		s_d.full  = single_i ? (s_d.count != '0) : (s_d.count == CW'(DEPTH));
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '{count: '0, empty: 1'b1, full: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign count_o = s_q.count;
	assign empty_o = s_q.empty;
	assign full_o  = s_q.full;

endmodule : ulfc_queue_ctl

/* File: src/ulfc_top.sv */
// Line control, queue control and interrupt identity with a Wishbone slave
//
// Register access over Wishbone was decided locally.
`timescale 1ns/10ps
module ulfc_top #(
	parameter int QUEUE_DEPTH = ulfc_pkg::ULFC_QUEUE_DEPTH,
	parameter int IR_PER_CYC  = ulfc_pkg::ULFC_IR_PER_CYC,
	parameter int IR_LOW_CYC  = ulfc_pkg::ULFC_IR_LOW_CYC
) (
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// Wishbone slave
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [31:0]             wb_adr_i,
	input  wire logic [31:0]             wb_dat_i,
	input  wire logic [3:0]              wb_sel_i,
	output logic [31:0]                  wb_dat_o,
	output logic                         wb_ack_o,
	// Framing engine
	input  wire ulfc_pkg::ulfc_frm_in_t  frm_i,
	output ulfc_pkg::ulfc_frm_out_t      frm_o,
	// Line pins
	output logic                         sout_o,
	output logic                         sir_out_n_o,
	// Interrupt
	output logic                         irq_o
);
	import ulfc_pkg::*;

	localparam int CW = $clog2(QUEUE_DEPTH + 1);

	typedef struct packed {
		logic              ack;
		logic [31:0]       rdata;
		logic [15:0]       lcr;
		logic [7:0]        modem_control;
		logic [15:0]       div;
		logic              qen;
		logic [ULFC_EV_W-1:0] ists;
		logic [ULFC_EV_W-1:0] imask;
		logic              irq;
		logic              sout;
		logic              sir_n;
		logic [15:0]       pcnt;
		logic              rx_empty_prev;
		logic              tx_empty_prev;
		logic [7:0]        tx_data;
		logic              tx_push;
		logic              loop_break;
	} ulfc_state_t;

	ulfc_state_t          s_q;
	ulfc_state_t          s_d;

	logic                 acc;
	logic                 wr;
	logic                 rd;
	logic                 dlab;
	logic                 qctl_wr;
	logic                 qen_chg;
	logic                 tx_clr;
	logic                 rx_clr;
	logic                 tx_push;
	logic                 rx_pop;
	logic [CW-1:0]        tx_cnt;
	logic [CW-1:0]        rx_cnt;
	logic                 tx_empty;
	logic                 rx_empty;
	logic                 tx_full;
	logic                 rx_full;
	logic [ULFC_EV_W-1:0] ev_set;
	logic [ULFC_EV_W-1:0] ev_clr;

	// Highest-priority pending source among unmasked status bits
	function automatic logic [3:0] ulfc_identity(input logic [ULFC_EV_W-1:0] p);
		logic [3:0] id;
		id = ULFC_IID_NONE;
		if (p[ULFC_EV_LSR]) begin
			id = ULFC_IID_LSR;
		end else if (p[ULFC_EV_RDA]) begin
			id = ULFC_IID_RDA;
		end else if (p[ULFC_EV_TMO]) begin
			id = ULFC_IID_TMO;
		end else if (p[ULFC_EV_THRE]) begin
			id = ULFC_IID_THRE;
		end else if (p[ULFC_EV_BUSY]) begin
			id = ULFC_IID_BUSY;
		end
		return id;
	endfunction : ulfc_identity

	// Bus phases: data is latched with ack, side effects land on the ack edge
	assign acc  = wb_cyc_i & wb_stb_i & s_q.ack;
	assign wr   = acc & wb_we_i & wb_sel_i[0];
	assign rd   = acc & ~wb_we_i;
	assign dlab = s_q.lcr[ULFC_LCR_DLAB];

	// Queue control strobes; flush bits are never stored so they self-clear
	assign qctl_wr = wr && (wb_adr_i == ULFC_QCTL_ADR);
	assign qen_chg = qctl_wr && (wb_dat_i[ULFC_QC_EN] != s_q.qen); // RQ4
	assign tx_clr  = qen_chg | (qctl_wr & wb_dat_i[ULFC_QC_TXFL]); // RQ4
	assign rx_clr  = qen_chg | (qctl_wr & wb_dat_i[ULFC_QC_RXFL]); // RQ2 RQ4

	// Data port reaches the queues only while divisor access is off
	assign tx_push = wr && !dlab && (wb_adr_i == ULFC_DATA_ADR); // RQ5
	assign rx_pop  = rd && !dlab && (wb_adr_i == ULFC_DATA_ADR); // RQ5

	// Transmit queue control
	ulfc_queue_ctl #(
		.DEPTH    (QUEUE_DEPTH),
		.CW       (CW)
	) u_txq (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.push_i   (tx_push),
		.pop_i    (frm_i.tx_pop),
		.clear_i  (tx_clr),
		.single_i (~s_q.qen), // RQ3
		.count_o  (tx_cnt),
		.empty_o  (tx_empty),
		.full_o   (tx_full)
	);

	// Receive queue control
	ulfc_queue_ctl #(
		.DEPTH    (QUEUE_DEPTH),
		.CW       (CW)
	) u_rxq (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.push_i   (frm_i.rx_push),
		.pop_i    (rx_pop),
		.clear_i  (rx_clr),
		.single_i (~s_q.qen), // RQ3
		.count_o  (rx_cnt),
		.empty_o  (rx_empty),
		.full_o   (rx_full)
	);

	// Interrupt events; an LCR write while busy counts as busy detect
	always_comb begin
		ev_set = '0;
		ev_set[ULFC_EV_LSR]  = frm_i.line_status;
		ev_set[ULFC_EV_RDA]  = s_q.rx_empty_prev & ~rx_empty;
		ev_set[ULFC_EV_TMO]  = frm_i.char_timeout;
		ev_set[ULFC_EV_THRE] = ~s_q.tx_empty_prev & tx_empty;
		ev_set[ULFC_EV_BUSY] = wr && (wb_adr_i == ULFC_LCR_ADR) && frm_i.busy;
		ev_clr = '0;
		if (wr && (wb_adr_i == ULFC_ISTS_ADR)) begin
			ev_clr = wb_dat_i[ULFC_EV_W-1:0];
		end
	end

	// Next state of the whole block
	always_comb begin
		logic [31:0] rdat;
		logic [ULFC_EV_W-1:0] pend;
		logic loop;
		logic brk;
		logic irm;
		rdat = '0;
		pend = s_q.ists & s_q.imask;
		loop = s_q.modem_control[ULFC_MCR_LOOP];
		brk  = s_q.lcr[ULFC_LCR_BC];
		irm  = s_q.modem_control[ULFC_MCR_IR];
		s_d  = s_q;

		// Register writes; the character goes to the framer with a one-cycle push
		s_d.tx_push = tx_push;
		if (tx_push) begin
			s_d.tx_data = wb_dat_i[7:0];
		end
		if (wr) begin
			if (wb_adr_i == ULFC_DATA_ADR) begin
				if (dlab) begin
					s_d.div[7:0] = wb_dat_i[7:0]; // RQ5
				end
			end else if (wb_adr_i == ULFC_DIVHI_ADR) begin
				if (dlab) begin
					s_d.div[15:8] = wb_dat_i[7:0]; // RQ5
				end
			end else if (wb_adr_i == ULFC_QCTL_ADR) begin
				s_d.qen = wb_dat_i[ULFC_QC_EN]; // RQ3
			end else if (wb_adr_i == ULFC_LCR_ADR) begin
				// While busy only the break bit may change
				if (frm_i.busy) begin
					s_d.lcr = (s_q.lcr & ~ULFC_LCR_BUSYMSK) | (wb_dat_i[15:0] & ULFC_LCR_BUSYMSK); // RQ6
				end else begin
					s_d.lcr = wb_dat_i[15:0] & ULFC_LCR_WMASK;
				end
			end else if (wb_adr_i == ULFC_MCR_ADR) begin
				s_d.modem_control = wb_dat_i[7:0];
			end else if (wb_adr_i == ULFC_IMASK_ADR) begin
				s_d.imask = wb_dat_i[ULFC_EV_W-1:0];
			end
		end

		// Sticky status: a new event beats a clear in the same cycle
		s_d.ists = (s_q.ists & ~ev_clr) | ev_set;
		s_d.irq  = |(s_d.ists & s_d.imask);
		// Built from next state so the registered copy matches the live bits
		s_d.loop_break = s_d.lcr[ULFC_LCR_BC] & s_d.modem_control[ULFC_MCR_LOOP]; // RQ11
		// Edge detectors start at the empty idle level, so reset makes no false event
		s_d.rx_empty_prev = rx_empty;
		s_d.tx_empty_prev = tx_empty;

		// Read mux, latched in the cycle that raises ack
		if (wb_adr_i == ULFC_DATA_ADR) begin
			rdat[7:0] = dlab ? s_q.div[7:0] : frm_i.rx_data; // RQ5
		end else if (wb_adr_i == ULFC_DIVHI_ADR) begin
			rdat[7:0] = dlab ? s_q.div[15:8] : 8'h00; // RQ5
		end else if (wb_adr_i == ULFC_QCTL_ADR) begin
			rdat[3:0] = ulfc_identity(pend); // RQ1 RQ12
			rdat[ULFC_ID_QEN_LO] = s_q.qen;
			rdat[ULFC_ID_QEN_HI] = s_q.qen;
		end else if (wb_adr_i == ULFC_LCR_ADR) begin
			rdat[15:0] = s_q.lcr;
		end else if (wb_adr_i == ULFC_MCR_ADR) begin
			rdat[7:0] = s_q.modem_control;
		end else if (wb_adr_i == ULFC_STAT_ADR) begin
			rdat[ULFC_ST_BUSY] = frm_i.busy;
			rdat[ULFC_ST_TXCNT +: CW] = tx_cnt;
			rdat[ULFC_ST_RXCNT +: CW] = rx_cnt;
		end else if (wb_adr_i == ULFC_ISTS_ADR) begin
			rdat[ULFC_EV_W-1:0] = s_q.ists;
		end else if (wb_adr_i == ULFC_IMASK_ADR) begin
			rdat[ULFC_EV_W-1:0] = s_q.imask;
		end

		// One wait state, ack for one cycle; unmapped reads return zero
		s_d.ack = wb_cyc_i & wb_stb_i & ~s_q.ack;
		if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
			s_d.rdata = rdat;
		end

		// Break pulse timer free-runs; only its phase during break matters
		if (s_q.pcnt >= 16'(IR_PER_CYC - 1)) begin
			s_d.pcnt = '0;
		end else begin
			s_d.pcnt = s_q.pcnt + 16'h0001;
		end

		// Line pins; loopback keeps the line marking unless break is set
		if (brk) begin
			s_d.sout = 1'b0; // RQ8 RQ9
		end else if (loop) begin
			s_d.sout = 1'b1;
		end else begin
			s_d.sout = frm_i.ser_tx;
		end
		if (loop) begin
			s_d.sir_n = 1'b0; // RQ11
		end else if (brk && irm) begin
			s_d.sir_n = ~(s_q.pcnt < 16'(IR_LOW_CYC)); // RQ10
		end else if (irm) begin
			s_d.sir_n = frm_i.ir_pulse_n;
		end else begin
			s_d.sir_n = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q       <= '0;
			s_q.lcr   <= ULFC_LCR_RST;
			s_q.modem_control   <= ULFC_MCR_RST;
			s_q.qen   <= ULFC_QEN_RST; // RQ3
			s_q.imask <= ULFC_IMASK_RST;
			s_q.sout  <= 1'b1;
			s_q.sir_n <= 1'b1;
			s_q.rx_empty_prev <= 1'b1;
			s_q.tx_empty_prev <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign wb_dat_o             = s_q.rdata;
	assign wb_ack_o             = s_q.ack;
	assign irq_o                = s_q.irq;
	assign sout_o               = s_q.sout;
	assign sir_out_n_o          = s_q.sir_n;
	assign frm_o.tx_data        = s_q.tx_data;
	assign frm_o.tx_push        = s_q.tx_push;
	assign frm_o.loop_break     = s_q.loop_break; // RQ11
	assign frm_o.loopback       = s_q.modem_control[ULFC_MCR_LOOP];
	assign frm_o.queue_enable   = s_q.qen;
	assign frm_o.divisor        = s_q.div;
	assign frm_o.line_control   = s_q.lcr;

endmodule : ulfc_top

/* File: verif/tb.sv */
// Self-checking bench for the line and queue control block
`timescale 1ns/10ps
module tb;
	import ulfc_pkg::*;
	localparam int PER = 8;
	localparam int LOW = 2;
	logic          clk_i, rst_i, cyc, stb, we, busy, wb_ack_o, sout_o, sir_out_n_o, irq_o;
	logic [2:0]    ev;
	logic [31:0]   adr, dat, wb_dat_o, q;
	ulfc_frm_in_t  frm_i;
	ulfc_frm_out_t frm_o;
	int            miscompares = 0, n_compared = 0, cycles = 0;

	ulfc_top #(.QUEUE_DEPTH(4), .IR_PER_CYC(PER), .IR_LOW_CYC(LOW)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frm_i(frm_i), .frm_o(frm_o), .sout_o(sout_o),
		.sir_out_n_o(sir_out_n_o), .irq_o(irq_o));
	ulfc_peer peer (.clk_i(clk_i), .rst_i(rst_i), .busy_i(busy), .ev_i(ev), .ctl_i(frm_o), .frm_o(frm_i));

	// Clock and hang guard
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			summarize();
		end
	end

	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	// Classic single cycle; holds the request until ack is seen
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		{cyc, stb} <= 2'b00;
	endtask : wb

	task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask : rd

	// One-cycle event via the peer: {rx push, line status, timeout}
	task automatic pulse(input logic [2:0] m);
		@(posedge clk_i);
		ev <= m;
		@(posedge clk_i);
		ev <= 3'h0;
		// Let the status bit settle before the next read latches it
		@(posedge clk_i);
	endtask : pulse

	task automatic lowcount(input bit ir, input int n, output int lows);
		lows = 0;
		repeat (2) @(posedge clk_i);
		repeat (n) begin
			@(posedge clk_i);
			lows += ((ir ? sir_out_n_o : sout_o) === 1'b0);
		end
	endtask : lowcount

	task automatic t_reset();
		rd(ULFC_LCR_ADR, 32'hffff, 32'h0);
		rd(ULFC_QCTL_ADR, 32'hcf, 32'hc1);
		rd(32'h50001020, 32'hffffffff, 32'h0);
		chk(32'(sout_o), 32'h1);
	endtask : t_reset

	// Every identity code; timeout, receive and line status each raised above a lower one
	task automatic t_ident();
		wb(1'b1, ULFC_IMASK_ADR, 32'h1f);
		wb(1'b1, ULFC_DATA_ADR, 32'h5a);
		repeat (6) @(posedge clk_i);
		chk(32'(frm_o.tx_data), 32'h5a);
		rd(ULFC_QCTL_ADR, 32'hf, 32'h2);
		chk(32'(irq_o), 32'h1);
		busy <= 1'b1;
		wb(1'b1, ULFC_LCR_ADR, 32'h9f);
		rd(ULFC_LCR_ADR, 32'hff, 32'h0);
		busy <= 1'b0;
		rd(ULFC_QCTL_ADR, 32'hf, 32'h2);
		wb(1'b1, ULFC_ISTS_ADR, 32'h8);
		rd(ULFC_QCTL_ADR, 32'hf, 32'h7);
		pulse(3'b001);
		rd(ULFC_QCTL_ADR, 32'hf, 32'hc);
		pulse(3'b100);
		rd(ULFC_QCTL_ADR, 32'hf, 32'h4);
		pulse(3'b010);
		rd(ULFC_QCTL_ADR, 32'hf, 32'h6);
		wb(1'b1, ULFC_IMASK_ADR, 32'h0);
		rd(ULFC_QCTL_ADR, 32'hf, 32'h1);
		chk(32'(irq_o), 32'h0);
		wb(1'b1, ULFC_ISTS_ADR, 32'h1f);
		wb(1'b1, ULFC_IMASK_ADR, 32'h1f);
		rd(ULFC_QCTL_ADR, 32'hf, 32'h1);
	endtask : t_ident

	task automatic t_queue();
		wb(1'b1, ULFC_QCTL_ADR, 32'h3);
		rd(ULFC_STAT_ADR, 32'h1f0000, 32'h0);
		pulse(3'b100);
		pulse(3'b100);
		rd(ULFC_STAT_ADR, 32'h1f0000, 32'h20000);
		wb(1'b1, ULFC_QCTL_ADR, 32'h0);
		rd(ULFC_STAT_ADR, 32'h1f0000, 32'h0);
		pulse(3'b100);
		pulse(3'b100);
		rd(ULFC_STAT_ADR, 32'h1f0000, 32'h10000);
		rd(ULFC_QCTL_ADR, 32'hc0, 32'h0);
		wb(1'b1, ULFC_QCTL_ADR, 32'h1);
		rd(ULFC_STAT_ADR, 32'h1f0000, 32'h0);
	endtask : t_queue

	task automatic t_dlab();
		wb(1'b1, ULFC_LCR_ADR, 32'h80);
		wb(1'b1, ULFC_DATA_ADR, 32'h34);
		wb(1'b1, ULFC_DIVHI_ADR, 32'h12);
		// The write lands on the ack edge; look one edge later
		@(posedge clk_i);
		chk(32'(frm_o.divisor), 32'h1234);
		rd(ULFC_DATA_ADR, 32'hff, 32'h34);
		wb(1'b1, ULFC_LCR_ADR, 32'h0);
		rd(ULFC_DIVHI_ADR, 32'hff, 32'h0);
	endtask : t_dlab

	task automatic t_break();
		int lows;
		wb(1'b1, ULFC_LCR_ADR, 32'h40);
		lowcount(1'b0, 20, lows);
		chk(lows, 32'd20);
		wb(1'b1, ULFC_MCR_ADR, 32'h40);
		lowcount(1'b1, 2 * PER, lows);
		chk(lows, 2 * LOW);
		wb(1'b1, ULFC_MCR_ADR, 32'h50);
		lowcount(1'b1, 4, lows);
		chk(lows, 32'd4);
		chk(32'(frm_o.loop_break), 32'h1);
		wb(1'b1, ULFC_LCR_ADR, 32'h0);
		lowcount(1'b0, 4, lows);
		chk(lows, 32'd0);
		wb(1'b1, ULFC_MCR_ADR, 32'h0);
	endtask : t_break

	initial begin
		{rst_i, cyc, stb, we, busy} = 5'h10;
		ev = 3'h0;
		adr = 32'h0;
		dat = 32'h0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_ident();
		t_queue();
		t_dlab();
		t_break();
		summarize();
	end
endmodule : tb

/* File: verif/ulfc_peer.sv */
// Behavioural framing engine and far line: events on command, takes sent characters late
`timescale 1ns/10ps
module ulfc_peer (
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// Commands from the bench
	input  wire logic                    busy_i,
	input  wire logic [2:0]              ev_i,
	// Block side
	input  wire ulfc_pkg::ulfc_frm_out_t ctl_i,
	output ulfc_pkg::ulfc_frm_in_t       frm_o
);
	import ulfc_pkg::*;
	logic [2:0] pop_q;
	// Serial bit toggles each cycle so a stale copy on sout cannot pass
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frm_o <= '0;
			pop_q <= 3'h0;
		end else begin
			frm_o.busy <= busy_i;
			frm_o.ser_tx <= ~frm_o.ser_tx;
			frm_o.ir_pulse_n <= 1'b1;
			{frm_o.rx_push, frm_o.line_status, frm_o.char_timeout} <= ev_i;
			frm_o.rx_data <= frm_o.rx_data + 8'h01;
			pop_q <= {pop_q[1:0], ctl_i.tx_push}; // Slow taker: pops each character four cycles after its push
			frm_o.tx_pop <= pop_q[2];
		end
	end
endmodule : ulfc_peer

/* File: verif/ulfc_props.sv */
// Port-level checker for the line and queue control block
`timescale 1ns/10ps
module ulfc_props (
	// Clock and reset
	input wire logic                    clk_i,
	input wire logic                    rst_i,
	// Bus handshake
	input wire logic                    wb_cyc_i,
	input wire logic                    wb_stb_i,
	input wire logic                    wb_ack_o,
	// Framing engine and line
	input wire ulfc_pkg::ulfc_frm_in_t  frm_i,
	input wire ulfc_pkg::ulfc_frm_out_t frm_o,
	input wire logic                    sout_o,
	input wire logic                    sir_out_n_o
);
	import ulfc_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// One answer a cycle after each request, never held
	a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	// Break wins over every other source of the serial bit
	a_break_low: assert property (frm_o.line_control[ULFC_LCR_BC] |=> !sout_o)
		else $error("sout high during break");
	a_sout_follow: assert property (!frm_o.line_control[ULFC_LCR_BC] && !frm_o.loopback
		|=> sout_o == $past(frm_i.ser_tx)) else $error("sout not following framer");
	a_loop_idle: assert property (frm_o.loopback && !frm_o.line_control[ULFC_LCR_BC] |=> sout_o)
		else $error("sout low in loopback");
	a_loop_ir_low: assert property (frm_o.loopback |=> !sir_out_n_o)
		else $error("infrared not forced low");
	a_loop_break: assert property (frm_o.loop_break == (frm_o.loopback && frm_o.line_control[ULFC_LCR_BC]))
		else $error("loop break wrong");
	// Busy locks the divisor access bit and the format bits
	a_busy_lock: assert property (frm_i.busy && $past(frm_i.busy)
		|=> $stable({frm_o.line_control[7], frm_o.line_control[4:0]})) else $error("lcr changed while busy");
	a_div_locked: assert property (!frm_o.line_control[ULFC_LCR_DLAB] |=> $stable(frm_o.divisor))
		else $error("divisor changed without access bit");
	c_break: cover property (frm_o.line_control[ULFC_LCR_BC] && !frm_o.loopback);
	c_loop_break: cover property (frm_o.loop_break);
	c_busy_write: cover property (frm_i.busy && wb_ack_o);
endmodule : ulfc_props
bind ulfc_top ulfc_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .frm_i(frm_i), .frm_o(frm_o), .sout_o(sout_o), .sir_out_n_o(sir_out_n_o));
